// [src/exprs_pkg.sv]
package exprs_pkg;

  // ---------------------------------------------------------------------------
  // Register selection on the coprocessor move port
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    EXPRS_SEL_RESUME = 2'b00,
    EXPRS_SEL_NESTED = 2'b01,
    EXPRS_SEL_NSTATE = 2'b10,
    EXPRS_SEL_IDENT  = 2'b11
  } exprs_sel_e;

  // ---------------------------------------------------------------------------
  // Exception classes as seen by this block
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    EXPRS_EXC_NORMAL = 2'b00,   // Loads resume address when level flag clear
    EXPRS_EXC_ERROR  = 2'b01,   // Reset, soft reset, nmi, cache error
    EXPRS_EXC_DEBUG  = 2'b10,   // Debug exception
    EXPRS_EXC_NONE   = 2'b11
  } exprs_exc_e;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int          EXPRS_NEST_ERL_BIT = 2;
  localparam int          EXPRS_NEST_EXL_BIT = 1;
  localparam int          EXPRS_ID_OPT_LSB   = 24;
  localparam int          EXPRS_ID_VEND_LSB  = 16;
  localparam int          EXPRS_ID_CORE_LSB  = 8;
  localparam int          EXPRS_REV_MAJ_LSB  = 5;
  localparam int          EXPRS_REV_MIN_LSB  = 2;
  localparam logic [31:0] EXPRS_ZERO32       = 32'h0000_0000;
  localparam logic [7:0]  EXPRS_OPT_MAX      = 8'h7f;

endpackage : exprs_pkg

// [src/exprs_ident_rom.sv]
`timescale 1ns/1ps
// Identification word builder; the word is held in a register
module exprs_ident_rom
  import exprs_pkg::*;
#(
  parameter logic [7:0] VENDOR_OPTION = 8'h00,
  parameter logic [7:0] VENDOR_CODE   = 8'h5a,  // Arbitrary value
  parameter logic [7:0] CORE_TYPE     = 8'h3c,  // Arbitrary value
  parameter logic [2:0] REV_MAJOR     = 3'h0,
  parameter logic [2:0] REV_MINOR     = 3'h0,
  parameter logic [1:0] REV_PATCH     = 2'h0
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Word out
  output logic [31:0]      ident_word
);

  typedef struct packed {
    logic [31:0] word;
  } exprs_rom_s;

  exprs_rom_s st, next_st;

  // ---------------------------------------------------------------------------
  // Field packing
  // ---------------------------------------------------------------------------
  // Option byte above the allowed range is clipped to keep supplier codes out
  always_comb begin
    next_st = st;
    next_st.word = EXPRS_ZERO32;
    next_st.word[EXPRS_ID_OPT_LSB +: 8] = (VENDOR_OPTION > EXPRS_OPT_MAX) ? EXPRS_OPT_MAX
                                                                           : VENDOR_OPTION;
    next_st.word[EXPRS_ID_VEND_LSB +: 8] = VENDOR_CODE;
    next_st.word[EXPRS_ID_CORE_LSB +: 8] = CORE_TYPE;
    next_st.word[EXPRS_REV_MAJ_LSB +: 3] = REV_MAJOR;
    next_st.word[EXPRS_REV_MIN_LSB +: 3] = REV_MINOR;
    next_st.word[1:0]                    = REV_PATCH;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ident_word = st.word;

endmodule : exprs_ident_rom

// [src/exprs_exception_state.sv]
`timescale 1ns/1ps
// What this block does
// - Copy prior error flag into nested bit 2
// - Copy prior exception flag into bit 1
// - Error, debug classes keep nested address, exception bit
// - Nested state other bits read zero
// - Resume address bits 31:1 significant, software writable
// - Load fault address or branch address, delay
// - Exception level set blocks hardware resume load
// - Read returns address bits 31:1, mode bit in bit 0
// - Write loads address, clears bit0, sets mode
// - Nested address captured on every normal exception
// - Return instructions never use nested address
// - Presence bit shows nested registers exist
// - Identification holds option, vendor, core, revision
// - Revision splits major, minor, patch fields
module exprs_exception_state
  import exprs_pkg::*;
#(
  parameter bit         NESTED_PRESENT = 1'b1,
  parameter logic [7:0] VENDOR_OPTION  = 8'h00,
  parameter logic [7:0] VENDOR_CODE    = 8'h5a,  // Arbitrary value
  parameter logic [7:0] CORE_TYPE      = 8'h3c,  // Arbitrary value
  parameter logic [2:0] REV_MAJOR      = 3'h0,
  parameter logic [2:0] REV_MINOR      = 3'h0,
  parameter logic [1:0] REV_PATCH      = 2'h0
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Exception accept from the pipeline
  input  wire logic        exc_accept,
  input  wire logic [1:0]  exc_class,
  input  wire logic [31:0] exc_fault_addr,
  input  wire logic [31:0] exc_branch_addr,
  input  wire logic        exc_in_delay_slot,
  // Status flags before the exception
  input  wire logic        exception_level_flag,
  input  wire logic        error_level_flag,
  // Current instruction set mode
  input  wire logic [1:0]  instruction_set_select,
  // Coprocessor move port
  input  wire logic        coproc_read_instr,
  input  wire logic        coproc_write_instr,
  input  wire logic [1:0]  coproc_sel,
  input  wire logic [31:0] coproc_wdata,
  // Results
  output logic [31:0]      coproc_rdata,
  output logic             coproc_rvalid,
  output logic [31:0]      return_address,
  output logic             branch_delay_set,
  output logic             mode_write,
  output logic [1:0]       next_mode,
  output logic             nested_fault_present_bit
);

  typedef struct packed {
    logic [31:0] resume;
    logic [31:0] nested;
    logic        nest_erl;
    logic        nest_exl;
    logic [31:0] rdata;
    logic        rvalid;
    logic        bd;
    logic        mwr;
    logic [1:0]  mode;
    logic        nf;
  } exprs_state_s;

  exprs_state_s st, next_st;
  logic [31:0]  ident_word;
  logic [31:0]  cap_addr;
  logic         normal_exc;

  // ---------------------------------------------------------------------------
  // Identification word
  // ---------------------------------------------------------------------------
  exprs_ident_rom #(
    .VENDOR_OPTION (VENDOR_OPTION),
    .VENDOR_CODE   (VENDOR_CODE),
    .CORE_TYPE     (CORE_TYPE),
    .REV_MAJOR     (REV_MAJOR),
    .REV_MINOR     (REV_MINOR),
    .REV_PATCH     (REV_PATCH)
  ) u_ident (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .ident_word (ident_word)
  );

  // Reads of resume registers splice the mode bit into bit 0
  function automatic logic [31:0] with_mode(input logic [31:0] a, input logic [1:0] m);
    with_mode = {a[31:1], m[0]};
  endfunction : with_mode

  // Branch in a delay slot reports the branch so the retry re-runs it
  assign cap_addr   = exc_in_delay_slot ? exc_branch_addr : exc_fault_addr;
  assign normal_exc = exc_accept && (exc_class == EXPRS_EXC_NORMAL);

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    next_st        = st;
    next_st.rvalid = 1'b0;
    next_st.bd     = 1'b0;
    next_st.mwr    = 1'b0;
    next_st.nf     = NESTED_PRESENT;
    // Software writes first; a same-cycle normal exception overrides below, but leaves a resume write when the level flag is set
    if (coproc_write_instr) begin
      if (coproc_sel == EXPRS_SEL_RESUME) begin
        next_st.resume = {coproc_wdata[31:1], 1'b0};
        next_st.mwr    = 1'b1;
        next_st.mode   = {1'b0, coproc_wdata[0]};
      end else if (coproc_sel == EXPRS_SEL_NESTED && NESTED_PRESENT) begin
        next_st.nested = {coproc_wdata[31:1], 1'b0};
        next_st.mwr    = 1'b1;
        next_st.mode   = {1'b0, coproc_wdata[0]};
      end
      // Nested state and identification ignore writes
    end
    if (normal_exc) begin
      if (!exception_level_flag) begin
        next_st.resume = cap_addr;
        next_st.bd     = exc_in_delay_slot;
      end
      if (NESTED_PRESENT) begin
        next_st.nested   = cap_addr;
        next_st.nest_exl = exception_level_flag;
        next_st.nest_erl = error_level_flag;
      end
    end
    // Error classes raise the error flag, so only its prior copy is taken;
    // the nested address and exception copy stay, debug changes nothing
    if (exc_accept && (exc_class == EXPRS_EXC_ERROR) && NESTED_PRESENT) begin
      next_st.nest_erl = error_level_flag;
    end
    if (coproc_read_instr) begin
      next_st.rvalid = 1'b1;
      if (coproc_sel == EXPRS_SEL_RESUME) begin
        next_st.rdata = with_mode(st.resume, instruction_set_select);
      end else if (coproc_sel == EXPRS_SEL_NESTED) begin
        next_st.rdata = NESTED_PRESENT ? with_mode(st.nested, instruction_set_select) : EXPRS_ZERO32;
      end else if (coproc_sel == EXPRS_SEL_NSTATE) begin
        next_st.rdata = EXPRS_ZERO32;
        next_st.rdata[EXPRS_NEST_ERL_BIT] = st.nest_erl & NESTED_PRESENT;
        next_st.rdata[EXPRS_NEST_EXL_BIT] = st.nest_exl & NESTED_PRESENT;
      end else begin
        next_st.rdata = ident_word;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Return instructions see only the primary resume address
  assign coproc_rdata             = st.rdata;
  assign coproc_rvalid            = st.rvalid;
  assign return_address           = st.resume;
  assign branch_delay_set         = st.bd;
  assign mode_write               = st.mwr;
  assign next_mode                = st.mode;
  assign nested_fault_present_bit = st.nf;

endmodule : exprs_exception_state

// [tb/exprs_exception_state_sva.sv]
`timescale 1ns/1ps
module exprs_exception_state_sva
  import exprs_pkg::*;
#(
  parameter bit NESTED_PRESENT = 1'b1
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  // Exception side
  input wire logic        exc_accept,
  input wire logic [1:0]  exc_class,
  input wire logic [31:0] exc_fault_addr,
  input wire logic [31:0] exc_branch_addr,
  input wire logic        exc_in_delay_slot,
  input wire logic        exception_level_flag,
  // Move port and results
  input wire logic        coproc_read_instr,
  input wire logic        coproc_write_instr,
  input wire logic [1:0]  coproc_sel,
  input wire logic [31:0] coproc_wdata,
  input wire logic [31:0] coproc_rdata,
  input wire logic        coproc_rvalid,
  input wire logic [31:0] return_address,
  input wire logic        branch_delay_set,
  input wire logic        mode_write,
  input wire logic [1:0]  next_mode,
  input wire logic        nested_fault_present_bit
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Hardware load of the resume address; a write in the same cycle loses to it
  logic hw_load;
  assign hw_load = exc_accept && exc_class == EXPRS_EXC_NORMAL && !exception_level_flag;
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  rd_valid_a: assert property (coproc_read_instr |=> coproc_rvalid) else $error("read without valid");
  nstate_zero_a: assert property (coproc_read_instr && coproc_sel == EXPRS_SEL_NSTATE |=>
    coproc_rdata[31:3] == '0 && !coproc_rdata[0]) else $error("nested state spare bits set");
  resume_wr_a: assert property (coproc_write_instr && coproc_sel == EXPRS_SEL_RESUME && !hw_load |=>
    return_address == {$past(coproc_wdata[31:1]), 1'b0}) else $error("resume write lost");
  mode_wr_a: assert property (coproc_write_instr && coproc_sel == EXPRS_SEL_RESUME && !exc_accept |=>
    mode_write && next_mode == {1'b0, $past(coproc_wdata[0])}) else $error("mode not updated");
  exc_load_a: assert property (hw_load |=> return_address == ($past(exc_in_delay_slot) ?
    $past(exc_branch_addr) : $past(exc_fault_addr))) else $error("resume address not loaded");
  exl_hold_a: assert property (exc_accept && exception_level_flag && !coproc_write_instr |=>
    $stable(return_address)) else $error("resume changed under level flag");
  bd_pulse_a: assert property (hw_load && exc_in_delay_slot |=> branch_delay_set) else $error("no delay flag");
  present_a: assert property (!sys_rst |=> nested_fault_present_bit == NESTED_PRESENT)
    else $error("presence bit wrong");
  // Main scenarios reached
  cover property (hw_load && exc_in_delay_slot);
  cover property (exc_accept && exception_level_flag);
  cover property (coproc_write_instr && coproc_sel == EXPRS_SEL_RESUME);
endmodule : exprs_exception_state_sva
bind exprs_exception_state exprs_exception_state_sva #(.NESTED_PRESENT(NESTED_PRESENT)) sva_u (.*);

// [tb/tb_exprs_exception_state.sv]
`timescale 1ns/1ps
module tb_exprs_exception_state;
  import exprs_pkg::*;
  // Identity values below are arbitrary
  localparam logic [7:0]  VCODE  = 8'h61;
  localparam logic [7:0]  CTYPE  = 8'h2d;
  localparam logic [31:0] ID_EXP = {8'h12, VCODE, CTYPE, 3'h5, 3'h2, 2'h1};
  // Stimulus and observed signals
  logic        ref_clk = 0, sys_rst = 1, exc_accept = 0, exc_in_delay_slot = 0;
  logic        exception_level_flag = 0, error_level_flag = 0, coproc_read_instr = 0, coproc_write_instr = 0;
  logic [1:0]  exc_class = 2'h3, instruction_set_select = 2'h0, coproc_sel = 2'h0, next_mode;
  logic [31:0] exc_fault_addr = '0, exc_branch_addr = '0, coproc_wdata = '0, coproc_rdata, return_address;
  logic        coproc_rvalid, branch_delay_set, mode_write, nested_fault_present_bit;
  int          error_cnt = 0, n_compared = 0;
  // Option byte preset inside the lower half of its range
  exprs_exception_state #(.VENDOR_OPTION(8'h12), .VENDOR_CODE(VCODE), .CORE_TYPE(CTYPE),
    .REV_MAJOR(3'h5), .REV_MINOR(3'h2), .REV_PATCH(2'h1)) dut_u (.*);
  // 250 MHz clock
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cp_wr(input logic [1:0] s, input logic [31:0] d);
    @(posedge ref_clk);
    coproc_write_instr <= 1'b1;
    coproc_sel         <= s;
    coproc_wdata       <= d;
    @(posedge ref_clk);
    coproc_write_instr <= 1'b0;
    #1;
  endtask : cp_wr
  // Read valid stands for one cycle only, so it is looked at right after the answer edge
  task automatic cp_rd(input logic [1:0] s, input logic [31:0] exp, input string nm);
    @(posedge ref_clk);
    coproc_read_instr <= 1'b1;
    coproc_sel        <= s;
    @(posedge ref_clk);
    coproc_read_instr <= 1'b0;
    #1;
    chk({nm, " valid"}, {31'h0, coproc_rvalid}, 32'h1);
    chk(nm, coproc_rdata, exp);
  endtask : cp_rd
  task automatic exc(input logic [1:0] c, input logic x, input logic r, input logic d,
                     input logic [31:0] fa, input logic [31:0] ba);
    @(posedge ref_clk);
    exc_accept           <= 1'b1;
    exc_class            <= c;
    exception_level_flag <= x;
    error_level_flag     <= r;
    exc_in_delay_slot    <= d;
    exc_fault_addr       <= fa;
    exc_branch_addr      <= ba;
    @(posedge ref_clk);
    exc_accept <= 1'b0;
    #1;
  endtask : exc
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // Watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    test_done();
  end
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    cp_rd(EXPRS_SEL_IDENT, ID_EXP, "ident");
    chk("present", {31'h0, nested_fault_present_bit}, 32'h1);
    cp_wr(EXPRS_SEL_IDENT, 32'hffff_ffff);
    cp_wr(EXPRS_SEL_NSTATE, 32'hffff_ffff);
    cp_rd(EXPRS_SEL_IDENT, ID_EXP, "ident after write");
    cp_rd(EXPRS_SEL_NSTATE, 32'h0, "nstate after write");
    cp_wr(EXPRS_SEL_RESUME, 32'h8765_4321);
    chk("mode", {29'h0, mode_write, next_mode}, 32'h5);
    chk("ret", return_address, 32'h8765_4320);
    @(posedge ref_clk) instruction_set_select <= 2'h1;
    cp_rd(EXPRS_SEL_RESUME, 32'h8765_4321, "resume isa1");
    @(posedge ref_clk) instruction_set_select <= 2'h2;
    cp_rd(EXPRS_SEL_RESUME, 32'h8765_4320, "resume isa2");
    exc(EXPRS_EXC_NORMAL, 1'b0, 1'b1, 1'b0, 32'h0000_1000, 32'h0000_0ff8);
    chk("ret exc", return_address, 32'h0000_1000);
    cp_rd(EXPRS_SEL_NSTATE, 32'h4, "nstate erl");
    cp_rd(EXPRS_SEL_NESTED, 32'h0000_1000, "nested");
    exc(EXPRS_EXC_NORMAL, 1'b1, 1'b0, 1'b1, 32'h0000_2000, 32'h0000_2ffc);
    chk("ret exl", return_address, 32'h0000_1000);
    cp_rd(EXPRS_SEL_NESTED, 32'h0000_2ffc, "nested exl");
    cp_rd(EXPRS_SEL_NSTATE, 32'h2, "nstate exl");
    exc(EXPRS_EXC_NORMAL, 1'b0, 1'b0, 1'b1, 32'h0000_3000, 32'h0000_3ffc);
    chk("bd", {31'h0, branch_delay_set}, 32'h1);
    chk("ret bd", return_address, 32'h0000_3ffc);
    // Error class takes only the prior error flag; debug leaves everything alone
    for (int k = 1; k < 3; k++) begin
      exc(2'(k), 1'b1, k == 1, 1'b0, 32'h0000_4000, 32'h0000_4000);
      cp_rd(EXPRS_SEL_NESTED, 32'h0000_3ffc, "nested hold");
      cp_rd(EXPRS_SEL_NSTATE, 32'h4, "nstate hold");
    end
    cp_wr(EXPRS_SEL_NESTED, 32'h0000_5550);
    chk("ret after nested write", return_address, 32'h0000_3ffc);
    cp_rd(EXPRS_SEL_NESTED, 32'h0000_5550, "nested write");
    cp_wr(EXPRS_SEL_RESUME, 32'h6666_0002);
    chk("ret sw under exl", return_address, 32'h6666_0002);
    test_done();
  end
endmodule : tb_exprs_exception_state
